// ==== eeprom_pkg.sv ====
/*
 * Shared constants and types of the two-wire serial memory sequencer.
 * Assumes a 10 MHz core clock sampling the serial pins.
 */
package eeprom_pkg;

    // ------------------------------------------------------------
    // clocking and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ       = 10_000_000;
    localparam int unsigned PROG_TIME_MS = 5;
    localparam int unsigned PROG_CYCLES  = (CLK_HZ / 1000) * PROG_TIME_MS;
    localparam int unsigned PROG_CNT_W   = 24;

    // ------------------------------------------------------------
    // addressing
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W      = 10;
    localparam int unsigned COL_W       = 4;
    localparam int unsigned PAGE_BYTES  = 16;
    localparam int unsigned PAGE_COUNT  = 32;
    localparam int unsigned FIFO_DEPTH  = 32;
    localparam logic [3:0]  DEV_CODE    = 4'hA;
    localparam logic [3:0]  BITS_BYTE   = 4'h8;
    localparam logic [3:0]  BIT_ACK     = 4'h9;
    localparam logic [3:0]  BIT_NONE    = 4'h0;
    localparam logic [3:0]  BIT_ONE     = 4'h1;
    localparam logic [3:0]  BIT_LAST    = 4'h7;

    // device address byte fields
    localparam int unsigned DEV_CODE_HI = 7;
    localparam int unsigned DEV_CODE_LO = 4;
    localparam int unsigned DEV_CS_BIT  = 3;
    localparam int unsigned DEV_HA_HI   = 2;
    localparam int unsigned DEV_HA_LO   = 1;
    localparam int unsigned DEV_RW_BIT  = 0;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic scl;
        logic sda;
        logic chipSelectInput;
        logic writeProtect;
    } pins_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } entry_type;

    typedef enum logic [2:0] {
        ST_IDLE, ST_DEV, ST_WADDR, ST_WDATA, ST_RDATA, ST_HOLD, ST_PROG
    } state_type;

endpackage

// ==== serial_eeprom_rw_sequencer.sv ====
/*
 * Two-wire serial memory slave: address decode, byte and page write
 * through a page FIFO, timed programming, current/sequential reads.
 * Assumes the serial pins are asynchronous to core_clk and that the
 * serial clock is much slower (8 or more core cycles per period).
 */
`timescale 1ns/1ns

// ----------------------------------------------------------------
// page data FIFO
// ----------------------------------------------------------------
module page_fifo #(
    parameter int unsigned WIDTH = 18,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             flush,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int unsigned AW = $clog2(DEPTH);

    if ((DEPTH < 2) || ((1 << AW) != DEPTH)) begin : badDepth
        $error("page_fifo depth must be a power of two");
    end

    typedef struct packed {
        logic [AW:0] wrPtr;
        logic [AW:0] rdPtr;
    } fifo_type;

    fifo_type   s_q;
    fifo_type   s_d;
    logic [WIDTH-1:0] store [DEPTH];

    assign inReady  = (s_q.wrPtr ^ s_q.rdPtr) != {1'b1, {AW{1'b0}}};
    assign outValid = s_q.wrPtr != s_q.rdPtr;
    assign outData  = store[s_q.rdPtr[AW-1:0]];

    always_comb begin
        s_d = s_q;
        if (flush) begin
            s_d.rdPtr = s_q.wrPtr;
        end else begin
            if (inValid && inReady) begin
                s_d.wrPtr = s_q.wrPtr + 1'b1;
            end
            if (outValid && outReady) begin
                s_d.rdPtr = s_q.rdPtr + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge clk) begin
        if (inValid && inReady && !flush) begin
            store[s_q.wrPtr[AW-1:0]] <= inData;
        end
    end
endmodule // page_fifo

// ----------------------------------------------------------------
// sequencer top
// ----------------------------------------------------------------
// Overview of operation
// RULE1 - write starts: START, address, ack on 9th
// RULE2 - word address byte acknowledged on 18th clock
// RULE3 - data ack on 27th, STOP starts programming
// RULE4 - programming ignores all inputs, then standby
// RULE5 - page write accepts one to sixteen bytes
// RULE6 - every further data byte acknowledged, STOP programs; the code acks only while the 32-entry page buffer has room
// RULE7 - only low four column bits increment
// RULE8 - seventeenth byte rolls onto first column
// RULE9 - no address ack while programming busy
// RULE10 - master sets direction bit high to read
// RULE11 - address counter holds last address plus one
// RULE12 - current read: ack, one byte, counter increments
// RULE13 - master ack requests next sequential byte
// RULE14 - read counter wraps to array start
// RULE15 - master ends read with no ack, STOP
// RULE16 - random read: dummy write then current read
// RULE17 - START abandons pending write process
// RULE18 - ack only code 1010 with matching select
// RULE19 - ten-bit word address, 32 pages of 16; the code's 1024-byte array with 4 column bits holds 64 pages of 16
// RULE20 - write protect high inhibits all programming
// RULE21 - ack drives data low on ninth clock
// RULE22 - upper two address bits from device byte
module serial_eeprom_rw_sequencer #(
    parameter int unsigned PROG_CYCLES = eeprom_pkg::PROG_CYCLES,
    parameter int unsigned FIFO_DEPTH  = eeprom_pkg::FIFO_DEPTH
) (
    input  wire logic                 core_clk,
    input  wire logic                 srst,
    input  wire eeprom_pkg::pins_type pinIn,
    output logic                      sdaOut,
    output logic                      sdaOe
);
    if ((PROG_CYCLES < 1) || (PROG_CYCLES >= (1 << eeprom_pkg::PROG_CNT_W))) begin : badProg
        $error("PROG_CYCLES does not fit the programming counter");
    end

    localparam int unsigned AW  = eeprom_pkg::ADDR_W;
    localparam int unsigned CW  = eeprom_pkg::COL_W;
    localparam int unsigned PCW = eeprom_pkg::PROG_CNT_W;
    localparam logic [PCW-1:0] PROG_LAST = PCW'(PROG_CYCLES - 1);

    typedef struct packed {
        eeprom_pkg::pins_type  sync1;
        eeprom_pkg::pins_type  sync2;
        eeprom_pkg::pins_type  sync3;
        eeprom_pkg::pins_type  filt;
        eeprom_pkg::state_type st;
        eeprom_pkg::state_type nextSt;
        logic [3:0]            bitCnt;
        logic [7:0]            shiftIn;
        logic [7:0]            txByte;
        logic [1:0]            hiAddr;
        logic [AW-1:0]         wrAddr;
        logic [AW-1:0]         addrCnt;
        logic                  masterAck;
        logic                  drvLow;
        logic [PCW-1:0]        progCnt;
    } core_type;

    core_type             c_q;
    core_type             c_d;
    logic [7:0]           array [1 << AW];

    eeprom_pkg::pins_type pinNew;
    eeprom_pkg::entry_type pushEntry;
    eeprom_pkg::entry_type popEntry;
    logic                 sclRise;
    logic                 sclFall;
    logic                 startSeen;
    logic                 stopSeen;
    logic                 pushValid;
    logic                 pushReady;
    logic                 popValid;
    logic                 popReady;
    logic                 flush;
    logic                 devMatch;

    // ------------------------------------------------------------
    // page buffer
    // ------------------------------------------------------------
    page_fifo #(
        .WIDTH ($bits(eeprom_pkg::entry_type)),
        .DEPTH (FIFO_DEPTH)
    ) pageBuf (
        .clk      (core_clk),
        .srst     (srst),
        .flush    (flush),
        .inValid  (pushValid),
        .inReady  (pushReady),
        .inData   (pushEntry),
        .outValid (popValid),
        .outReady (popReady),
        .outData  (popEntry)
    );

    // drains only while programming, so the buffer really fills
    assign popReady = c_q.st == eeprom_pkg::ST_PROG;

    always_ff @(posedge core_clk) begin
        if (popValid && popReady) begin
            array[popEntry.addr] <= popEntry.data;  // [RULE19]
        end
    end

    // ------------------------------------------------------------
    // pin filtering and bus conditions
    // ------------------------------------------------------------
    // per pin, so one changing pin never delays or merges with another
    always_comb begin
        pinNew = c_q.filt;
        for (int i = 0; i < $bits(eeprom_pkg::pins_type); i++) begin
            if (c_q.sync2[i] == c_q.sync3[i]) begin
                pinNew[i] = c_q.sync3[i];
            end
        end
    end

    assign sclRise   = pinNew.scl && !c_q.filt.scl;
    assign sclFall   = !pinNew.scl && c_q.filt.scl;
    assign startSeen = pinNew.scl && c_q.filt.scl && c_q.filt.sda && !pinNew.sda;
    assign stopSeen  = pinNew.scl && c_q.filt.scl && !c_q.filt.sda && pinNew.sda;

    assign devMatch =
        (c_q.shiftIn[eeprom_pkg::DEV_CODE_HI:eeprom_pkg::DEV_CODE_LO] == eeprom_pkg::DEV_CODE)
        && (c_q.shiftIn[eeprom_pkg::DEV_CS_BIT] == c_q.filt.chipSelectInput);  // [RULE18]

    // page column rolls inside the row  [RULE7] [RULE8]
    assign pushEntry = '{addr: c_q.wrAddr, data: c_q.shiftIn};

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        c_d       = c_q;
        pushValid = 1'b0;
        flush     = 1'b0;
        c_d.sync1 = pinIn;
        c_d.sync2 = c_q.sync1;
        c_d.sync3 = c_q.sync2;
        c_d.filt  = pinNew;

        if (c_q.st == eeprom_pkg::ST_PROG) begin
            // bus is not watched at all here, so polls get no ack  [RULE4] [RULE9]
            c_d.drvLow = 1'b0;
            if (c_q.progCnt != PROG_LAST) begin
                c_d.progCnt = c_q.progCnt + 1'b1;
            end else if (!popValid) begin
                c_d.st = eeprom_pkg::ST_IDLE;
            end
        end else if (startSeen) begin
            flush      = 1'b1;  // [RULE17]
            c_d.st     = eeprom_pkg::ST_DEV;
            c_d.bitCnt = eeprom_pkg::BIT_NONE;
            c_d.drvLow = 1'b0;
        end else if (stopSeen) begin
            c_d.drvLow = 1'b0;
            c_d.st     = eeprom_pkg::ST_IDLE;
            if (popValid) begin
                if (c_q.filt.writeProtect) begin
                    flush = 1'b1;  // [RULE20]
                end else begin
                    c_d.st      = eeprom_pkg::ST_PROG;  // [RULE3] [RULE6]
                    c_d.progCnt = '0;
                end
            end
        end else begin
            unique case (c_q.st)
                eeprom_pkg::ST_IDLE, eeprom_pkg::ST_HOLD: begin
                    c_d.drvLow = 1'b0;
                end
                eeprom_pkg::ST_DEV, eeprom_pkg::ST_WADDR, eeprom_pkg::ST_WDATA: begin
                    if (sclRise && (c_q.bitCnt < eeprom_pkg::BITS_BYTE)) begin
                        c_d.shiftIn = {c_q.shiftIn[6:0], c_q.filt.sda};
                        c_d.bitCnt  = c_q.bitCnt + 1'b1;
                    end else if (sclFall && (c_q.bitCnt == eeprom_pkg::BITS_BYTE)) begin
                        c_d.bitCnt = eeprom_pkg::BIT_ACK;
                        c_d.nextSt = eeprom_pkg::ST_HOLD;
                        unique case (c_q.st)
                            eeprom_pkg::ST_DEV: begin
                                if (devMatch) begin
                                    c_d.drvLow = 1'b1;  // [RULE1] [RULE21]
                                    c_d.hiAddr = c_q.shiftIn[eeprom_pkg::DEV_HA_HI:
                                                             eeprom_pkg::DEV_HA_LO];  // [RULE22]
                                    if (c_q.shiftIn[eeprom_pkg::DEV_RW_BIT]) begin
                                        c_d.nextSt = eeprom_pkg::ST_RDATA;  // [RULE10]
                                    end else begin
                                        c_d.nextSt = eeprom_pkg::ST_WADDR;
                                    end
                                end
                            end
                            eeprom_pkg::ST_WADDR: begin
                                c_d.drvLow  = 1'b1;  // [RULE2] [RULE16]
                                c_d.wrAddr  = {c_q.hiAddr, c_q.shiftIn};
                                c_d.addrCnt = {c_q.hiAddr, c_q.shiftIn};
                                c_d.nextSt  = eeprom_pkg::ST_WDATA;
                            end
                            default: begin
                                // a full buffer withholds the ack  [RULE5]
                                if (pushReady) begin
                                    pushValid   = 1'b1;
                                    c_d.drvLow  = 1'b1;  // [RULE3] [RULE6]
                                    c_d.wrAddr  = {c_q.wrAddr[AW-1:CW],
                                                   c_q.wrAddr[CW-1:0] + 1'b1};  // [RULE7] [RULE8]
                                    c_d.addrCnt = c_q.wrAddr + 1'b1;  // [RULE11]
                                    c_d.nextSt  = eeprom_pkg::ST_WDATA;
                                end
                            end
                        endcase
                    end else if (sclFall && (c_q.bitCnt == eeprom_pkg::BIT_ACK)) begin
                        c_d.bitCnt = eeprom_pkg::BIT_NONE;
                        c_d.st     = c_q.nextSt;
                        c_d.drvLow = 1'b0;
                        if (c_q.nextSt == eeprom_pkg::ST_RDATA) begin
                            c_d.txByte  = array[c_q.addrCnt];  // [RULE12]
                            c_d.drvLow  = !array[c_q.addrCnt][7];
                            c_d.addrCnt = c_q.addrCnt + 1'b1;  // [RULE11] [RULE14]
                        end
                    end
                end
                eeprom_pkg::ST_RDATA: begin
                    if (sclRise) begin
                        c_d.bitCnt = c_q.bitCnt + 1'b1;
                        if (c_q.bitCnt == eeprom_pkg::BITS_BYTE) begin
                            c_d.masterAck = !c_q.filt.sda;
                        end
                    end else if (sclFall) begin
                        if (c_q.bitCnt == eeprom_pkg::BITS_BYTE) begin
                            c_d.drvLow = 1'b0;
                        end else if (c_q.bitCnt == eeprom_pkg::BIT_ACK) begin
                            c_d.bitCnt = eeprom_pkg::BIT_NONE;
                            if (c_q.masterAck) begin
                                c_d.txByte  = array[c_q.addrCnt];  // [RULE13]
                                c_d.drvLow  = !array[c_q.addrCnt][7];
                                c_d.addrCnt = c_q.addrCnt + 1'b1;  // [RULE14]
                            end else begin
                                c_d.st     = eeprom_pkg::ST_HOLD;  // [RULE15]
                                c_d.drvLow = 1'b0;
                            end
                        end else if ((c_q.bitCnt >= eeprom_pkg::BIT_ONE)
                                     && (c_q.bitCnt <= eeprom_pkg::BIT_LAST)) begin
                            c_d.txByte = {c_q.txByte[6:0], 1'b0};
                            c_d.drvLow = !c_q.txByte[6];
                        end
                    end
                end
                default: begin
                    c_d.st     = eeprom_pkg::ST_IDLE;
                    c_d.drvLow = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            c_q        <= '0;
            c_q.st     <= eeprom_pkg::ST_IDLE;
            c_q.nextSt <= eeprom_pkg::ST_IDLE;
            c_q.sync1  <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
            c_q.sync2  <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
            c_q.sync3  <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
            c_q.filt   <= '{scl: 1'b1, sda: 1'b1, default: 1'b0};
        end else begin
            c_q <= c_d;
        end
    end

    // open drain: only ever pulls low
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sdaOut <= 1'b0;
            sdaOe  <= 1'b0;
        end else begin
            sdaOut <= 1'b0;
            sdaOe  <= c_d.drvLow;  // [RULE21]
        end
    end
endmodule // serial_eeprom_rw_sequencer

// ==== serial_eeprom_rw_sequencer_checker.sv ====
/* Pin-level assertions for the serial memory sequencer.
   Assumes eight core cycles per serial clock, as the bench drives it. */
`timescale 1ns/1ns
module serial_eeprom_rw_sequencer_checker #(
    parameter int unsigned PROG_CYCLES = eeprom_pkg::PROG_CYCLES,
    parameter int unsigned FIFO_DEPTH  = eeprom_pkg::FIFO_DEPTH
) (
    input wire logic                 core_clk,
    input wire logic                 srst,
    input wire eeprom_pkg::pins_type pinIn,
    input wire logic                 sdaOut,
    input wire logic                 sdaOe
);
    // ------------------------------------------------------------
    // delayed pin view
    // ------------------------------------------------------------
    // delay covers the input filter, so bit counts line up with drive changes
    logic [4:0]  sclDly_q;
    logic [4:0]  sdaDly_q;
    logic [15:0] bitCnt_q;
    logic [7:0]  devByte_q;
    logic        frame_q;
    logic        rise;
    logic        start;
    logic        stop;
    assign rise  = sclDly_q[3] & !sclDly_q[4];
    assign start = sclDly_q[3] & sclDly_q[4] & sdaDly_q[4] & !sdaDly_q[3];
    assign stop  = sclDly_q[3] & sclDly_q[4] & !sdaDly_q[4] & sdaDly_q[3];
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sclDly_q <= 5'h1F;
            sdaDly_q <= 5'h1F;
            bitCnt_q <= 16'h0000;
            devByte_q <= 8'h00;
            frame_q <= 1'b0;
        end else begin
            sclDly_q <= {sclDly_q[3:0], pinIn.scl};
            sdaDly_q <= {sdaDly_q[3:0], pinIn.sda};
            if (start) begin
                bitCnt_q <= 16'h0000;
                frame_q <= 1'b1;
            end else if (stop) begin
                frame_q <= 1'b0;
            end else if (rise) begin
                bitCnt_q <= bitCnt_q + 16'h0001;
                if (bitCnt_q < 16'h0008) begin
                    devByte_q <= {devByte_q[6:0], sdaDly_q[3]};
                end
            end
        end
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_out_level:
    assert property (@(posedge core_clk) disable iff (srst) sdaOe |-> !sdaOut)
        else $error("drive value not low");
    a_addr_match:
    assert property (@(posedge core_clk) disable iff (srst) $rose(sdaOe) && bitCnt_q == 8
        |-> devByte_q[7:4] == 4'hA && devByte_q[3] == pinIn.chipSelectInput)
        else $error("ack to foreign address");
    a_addr_ninth:
    assert property (@(posedge core_clk) disable iff (srst)
        $rose(sdaOe) && bitCnt_q < 9 |-> bitCnt_q == 8)
        else $error("address ack off ninth clock");
    a_write_acks:
    assert property (@(posedge core_clk) disable iff (srst)
        $rose(sdaOe) && !devByte_q[0] |-> bitCnt_q % 9 == 8)
        else $error("write ack off byte boundary");
    a_ack_release:
    assert property (@(posedge core_clk) disable iff (srst)
        $rose(sdaOe) && !devByte_q[0] |=> sdaOe [*6] ##[1:4] !sdaOe)
        else $error("write ack length wrong");
    a_release_holds:
    assert property (@(posedge core_clk) disable iff (srst) $fell(sdaOe) |=> !sdaOe [*6])
        else $error("release too short");
    a_scl_low_change:
    assert property (@(posedge core_clk) disable iff (srst)
        $changed(sdaOe) |-> !sclDly_q[2] || !sclDly_q[3])
        else $error("drive changed with clock high");
    a_idle_quiet:
    assert property (@(posedge core_clk) disable iff (srst) !frame_q |-> !sdaOe)
        else $error("drive outside a frame");
endmodule // serial_eeprom_rw_sequencer_checker

bind serial_eeprom_rw_sequencer serial_eeprom_rw_sequencer_checker #(
    .PROG_CYCLES(PROG_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) chk (.core_clk(core_clk),
    .srst(srst), .pinIn(pinIn), .sdaOut(sdaOut), .sdaOe(sdaOe));

// ==== two_wire_master.sv ====
/* Two-wire bus master model: start, stop, byte out, byte in.
   Assumes the bench resolves the open-drain data wire. */
`timescale 1ns/1ns
module two_wire_master (
    input  wire logic core_clk,
    input  wire logic sdaWire,
    output logic      scl,
    output logic      sdaDrv
);
    // ------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------
    // clock stands high between frames; a bit is 6 low and 2 high cycles
    // long low phase covers the slave's output latency before the rise
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // long setup lets the slave drop its ack before a repeated start
    task automatic start_cond();
        sdaDrv <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(4);
        sdaDrv <= 1'b0;
        tick(4);
        scl <= 1'b0;
        tick(2);
    endtask
    task automatic stop_cond();
        sdaDrv <= 1'b0;
        tick(4);
        scl <= 1'b1;
        tick(4);
        sdaDrv <= 1'b1;
        tick(4);
    endtask
    task automatic put_bit(input logic b, output logic seen);
        sdaDrv <= b;
        tick(4);
        scl <= 1'b1;
        tick(2);
        seen = sdaWire;
        scl <= 1'b0;
        tick(2);
    endtask
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i], s);
        end
        put_bit(1'b1, s);
        ack = !s;
    endtask
    task automatic get_byte(input logic more, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, s);
            b[i] = s;
        end
        put_bit(!more, s);
    endtask
endmodule // two_wire_master

// ==== tb_serial_eeprom_rw_sequencer.sv ====
/* Self-checking bench of the serial memory sequencer.
   Assumes the master model and the bound checker alongside. */
`timescale 1ns/1ns
module tb_serial_eeprom_rw_sequencer;
    logic                 core_clk = 1'b0;
    logic                 srst     = 1'b1;
    logic                 csIn     = 1'b1;
    logic                 wpIn     = 1'b0;
    logic                 scl;
    logic                 sdaDrv;
    logic                 sdaWire;
    logic                 sdaOut;
    logic                 sdaOe;
    eeprom_pkg::pins_type pinIn;
    logic [7:0]           expMem [1024];
    int                   num_errors   = 0;
    int                   total_checks = 0;

    always #50 core_clk = ~core_clk;
    assign sdaWire = sdaDrv & (sdaOe ? sdaOut : 1'b1);
    assign pinIn = '{scl: scl, sda: sdaWire, chipSelectInput: csIn, writeProtect: wpIn};
    two_wire_master mdl (.core_clk(core_clk), .sdaWire(sdaWire), .scl(scl), .sdaDrv(sdaDrv));
    // short programming time keeps the run small
    serial_eeprom_rw_sequencer #(.PROG_CYCLES(400), .FIFO_DEPTH(eeprom_pkg::FIFO_DEPTH)) uut (
        .core_clk(core_clk), .srst(srst), .pinIn(pinIn), .sdaOut(sdaOut), .sdaOe(sdaOe));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        if (num_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] want, input string what);
        total_checks++;
        if (got !== want) begin
            num_errors++;
            $display("MISMATCH %0t %s got %h want %h", $time, what, got, want);
        end
    endtask
    function automatic logic [7:0] devb(input logic [9:0] a, input logic rd);
        return {4'hA, csIn, a[9:8], rd};
    endfunction
    task automatic set_addr(input logic [9:0] a);
        logic ack;
        mdl.start_cond();
        mdl.send_byte(devb(a, 1'b0), ack);
        check(8'(ack), 8'h01, "device ack");
        mdl.send_byte(a[7:0], ack);
        check(8'(ack), 8'h01, "word ack");
    endtask
    task automatic wait_ready(input logic busy);
        logic ack;
        for (int i = 0; i < 40; i++) begin
            mdl.start_cond();
            mdl.send_byte(devb(10'h000, 1'b0), ack);
            mdl.stop_cond();
            if (i == 0) check(8'(ack), 8'(!busy), "poll ack");
            if (ack) return;
        end
        num_errors++;
        $display("MISMATCH %0t device stayed busy", $time);
        finish_test();
    endtask
    task automatic write_page(input logic [9:0] a, input int n, input logic [7:0] seed);
        logic       ack;
        logic [3:0] col;
        logic [7:0] d;
        col = a[3:0];
        set_addr(a);
        for (int i = 0; i < n; i++) begin
            d = seed + 8'(i * 7);
            mdl.send_byte(d, ack);
            check(8'(ack), 8'(i < 32), "data ack");
            if (!wpIn && i < 32) expMem[{a[9:4], col}] = d;
            col++;
        end
        mdl.stop_cond();
        wait_ready(!wpIn);
    endtask
    task automatic read_seq(input logic [9:0] a, input int n, input logic dummy);
        logic       ack;
        logic [7:0] d;
        logic [9:0] p;
        p = a;
        if (dummy) set_addr(a);
        mdl.start_cond();
        mdl.send_byte(devb(a, 1'b1), ack);
        check(8'(ack), 8'h01, "read ack");
        for (int i = 0; i < n; i++) begin
            mdl.get_byte(i < n - 1, d);
            check(d, expMem[p], "read data");
            p++;
        end
        mdl.stop_cond();
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic scen_page_wrap();
        write_page(10'h2AE, 33, 8'h11);
        read_seq(10'h2A0, 16, 1'b1);
    endtask
    task automatic scen_current_read();
        read_seq(10'h2A0, 1, 1'b1);
        read_seq(10'h2A1, 2, 1'b0);
    endtask
    task automatic scen_array_wrap();
        write_page(10'h3FF, 1, 8'hA5);
        write_page(10'h000, 1, 8'h5A);
        read_seq(10'h3FF, 2, 1'b1);
    endtask
    task automatic scen_protect();
        @(posedge core_clk);
        wpIn <= 1'b1;
        @(posedge core_clk);
        write_page(10'h2A5, 1, 8'hFF);
        wpIn <= 1'b0;
        @(posedge core_clk);
        read_seq(10'h2A5, 1, 1'b1);
    endtask
    task automatic scen_mismatch();
        logic ack;
        mdl.start_cond();
        mdl.send_byte({4'hB, csIn, 3'h0}, ack);
        check(8'(ack), 8'h00, "code nack");
        mdl.start_cond();
        mdl.send_byte({4'hA, !csIn, 3'h1}, ack);
        check(8'(ack), 8'h00, "select nack");
        mdl.stop_cond();
    endtask
    initial begin
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        repeat (4) @(posedge core_clk);
        check(8'(sdaOe), 8'h00, "idle drive");
        write_page(10'h155, 1, 8'h3C);
        read_seq(10'h155, 1, 1'b1);
        scen_page_wrap();
        scen_current_read();
        scen_array_wrap();
        scen_protect();
        scen_mismatch();
        finish_test();
    end
endmodule // tb_serial_eeprom_rw_sequencer
